// *** src/mie_exec_core.sv ***
// Instruction execution core with its AXI4-Lite register port
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
// Summary of operation
// [RQ1] Plain rotates move memory byte one place to acc or memory; flags kept.
// [RQ2] Rotates through carry rotate nine bits; only carry changes.
// [RQ3] Transfers copy acc to memory, memory to acc, immediate to acc; flags kept.
// [RQ4] Loading acc from memory leaves the zero flag alone.
// [RQ5] Bit clear and set force one selected bit 0..7; flags kept.
// [RQ6] Branch and subroutine entry carry a 10-bit target address.
// [RQ7] Memory operands use the 7-bit address field.
// [RQ8] Immediates are 8 bits taken straight from the instruction.
// [RQ9] Bit-test skips skip when bit is zero, or one; flags kept.
// [RQ10] Increment or decrement skips store result, skip on zero; flags kept.
// [RQ11] Skip-on-null with copy loads acc and skips on zero byte.
// [RQ12] Exit with immediate restores return address and loads acc.
// [RQ13] Table fetch reads ROM word: low byte to memory, upper bits to table byte.
// [RQ14] Halt enters power-down and updates watchdog-expired and sleep flags.
// [RQ15] Nibble exchange swaps halves into memory or acc; flags kept.
// [RQ16] Sum with carry to acc updates overflow, zero, half and full carry.
// [RQ17] Sum with carry to memory updates the same four flags only.
// [RQ18] Plain sum to acc updates the same four flags only.
// [RQ19] A met skip turns the next instruction into a no-operation.
// [RQ20] Pre-clear operations clear the watchdog only when both run back to back.
module mie_exec_core
   import mie_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [PC_W-1:0] romAddr,
   input wire logic [ROM_W-1:0] romData,
   output logic sleepMode,
   output logic wdtClear
);
   logic [DATA_W-1:0] mem_q [MEM_DEPTH];
   logic [PC_W-1:0] stack_q [STACK_DEPTH];
   logic [DATA_W-1:0] acc_q, accD;
   mie_status_t flag_q, flagD, addFl;
   logic [PC_W-1:0] pc_q, pcD, romAddr_q;
   logic [SP_W-1:0] sp_q;
   logic [TABLE_UPPER_BYTE_W-1:0] table_upper_byte_q;
   logic [MADDR_W-1:0] mptr_q, tabAddr_q;
   logic [1:0] wdtArm_q, armD;
   logic skipPending_q, skipD, sleep_q, wdtClear_q, wdtD;
   mie_state_t state_q;
   logic bValid_q, rValid_q;
   logic [1:0] bResp_q, rResp_q;
   logic [31:0] rData_q;
   mie_instr_t ins;
   mie_op_t opEff;
   logic [7:0] wIdx;
   logic wrGo, arGo, exe, memWe, pushEn, popEn, tabGo, haltGo, cin;
   logic swAcc, swStat, swState, swMptr, swMdata;
   logic [DATA_W-1:0] memRd, memWd, bitMask, incV, decV;
   logic [8:0] sum9;
   logic [4:0] sum5;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // Word-aligned register offset of a byte address
   function automatic logic [7:0] wordAddr(input logic [7:0] a);
      return {a[7:2], 2'b00};
   endfunction

   // Every word up to the memory data port is decoded
   function automatic logic isMapped(input logic [7:0] a);
      return wordAddr(a) <= REG_MDATA;
   endfunction

   // Write channel: address and data are taken together, never during a table fetch
   assign wrGo = s_axi_awvalid && s_axi_wvalid && !bValid_q && (state_q == ST_READY);
   assign s_axi_awready = wrGo;
   assign s_axi_wready = wrGo;
   assign wIdx = wordAddr(s_axi_awaddr);
   assign ins = mie_instr_t'(s_axi_wdata);

   // Register strobes; narrow registers need only the low byte lane
   assign exe = wrGo && (wIdx == REG_INSTR) && (&s_axi_wstrb) && !sleep_q;
   assign swAcc = wrGo && (wIdx == REG_ACC) && s_axi_wstrb[0];
   assign swStat = wrGo && (wIdx == REG_STATUS) && s_axi_wstrb[0];
   assign swState = wrGo && (wIdx == REG_STATE) && s_axi_wstrb[0];
   assign swMptr = wrGo && (wIdx == REG_MPTR) && s_axi_wstrb[0];
   assign swMdata = wrGo && (wIdx == REG_MDATA) && s_axi_wstrb[0];

   // A pending skip replaces the next instruction by a no-operation
   assign opEff = skipPending_q ? OP_NOP : ins.op; // [RQ19]

   // Operand fetch from the 7-bit addressed data memory
   assign memRd = mem_q[ins.memAddr]; // [RQ7]
   assign bitMask = 8'h01 << ins.bitSel; // [RQ5]
   assign incV = memRd + 8'h01;
   assign decV = memRd - 8'h01;

   // Adder; carry enters only for the with-carry forms
   assign cin = flag_q.cy && (opEff inside {OP_SUM_WITH_CY_TO_ACC, OP_SUM_WITH_CY_TO_MEMORY});
   assign sum9 = {1'b0, acc_q} + {1'b0, memRd} + {8'h00, cin};
   assign sum5 = {1'b0, acc_q[3:0]} + {1'b0, memRd[3:0]} + {4'h0, cin};

   // Arithmetic flags; general, watchdog and sleep flags pass through
   always_comb begin
      addFl = flag_q;
      addFl.cy = sum9[8];
      addFl.ac = sum5[4];
      addFl.z = (sum9[7:0] == 8'h00);
      addFl.ov = (acc_q[7] == memRd[7]) && (sum9[7] != acc_q[7]);
   end

   // Next architectural state for the instruction on the write channel
   always_comb begin
      accD = acc_q;
      flagD = flag_q;
      memWe = 1'b0;
      memWd = memRd;
      skipD = 1'b0;
      pcD = pc_q + 10'h001;
      pushEn = 1'b0;
      popEn = 1'b0;
      tabGo = 1'b0;
      haltGo = 1'b0;
      wdtD = 1'b0;
      armD = 2'b00;
      case (opEff)
         OP_ROTATE_RIGHT_TO_ACC: accD = {memRd[0], memRd[7:1]}; // [RQ1]
         OP_ROTATE_RIGHT_IN_PLACE: begin
            memWe = 1'b1;
            memWd = {memRd[0], memRd[7:1]}; // [RQ1]
         end
         OP_ROTATE_LEFT_TO_ACC: accD = {memRd[6:0], memRd[7]}; // [RQ1]
         OP_ROTATE_LEFT_IN_PLACE: begin
            memWe = 1'b1;
            memWd = {memRd[6:0], memRd[7]}; // [RQ1]
         end
         OP_ROTATE_RIGHT_VIA_CY_TO_ACC: begin
            accD = {flag_q.cy, memRd[7:1]}; // [RQ2]
            flagD.cy = memRd[0];
         end
         OP_ROTATE_RIGHT_VIA_CY: begin
            memWe = 1'b1;
            memWd = {flag_q.cy, memRd[7:1]}; // [RQ2]
            flagD.cy = memRd[0];
         end
         OP_ROTATE_LEFT_VIA_CY_TO_ACC: begin
            accD = {memRd[6:0], flag_q.cy}; // [RQ2]
            flagD.cy = memRd[7];
         end
         OP_ROTATE_LEFT_VIA_CY: begin
            memWe = 1'b1;
            memWd = {memRd[6:0], flag_q.cy}; // [RQ2]
            flagD.cy = memRd[7];
         end
         // Zero flag deliberately untouched on the memory load
         OP_TRANSFER_MEM_TO_ACC: accD = memRd; // [RQ3] [RQ4]
         OP_TRANSFER_ACC_TO_MEM: begin
            memWe = 1'b1;
            memWd = acc_q; // [RQ3]
         end
         OP_TRANSFER_IMM_TO_ACC: accD = ins.operand[7:0]; // [RQ3] [RQ8]
         OP_BIT_CLEAR: begin
            memWe = 1'b1;
            memWd = memRd & ~bitMask; // [RQ5]
         end
         OP_BIT_SET: begin
            memWe = 1'b1;
            memWd = memRd | bitMask; // [RQ5]
         end
         OP_UNCONDITIONAL_BRANCH: pcD = ins.operand; // [RQ6]
         OP_SUBROUTINE_ENTRY: begin
            pushEn = 1'b1;
            pcD = ins.operand; // [RQ6]
         end
         OP_SUBROUTINE_EXIT: begin
            popEn = 1'b1;
            pcD = stack_q[sp_q - 2'h1];
         end
         OP_SUBROUTINE_EXIT_IMM: begin
            popEn = 1'b1;
            pcD = stack_q[sp_q - 2'h1]; // [RQ12]
            accD = ins.operand[7:0]; // [RQ12] [RQ8]
         end
         OP_SKIP_ON_NULL: skipD = (memRd == 8'h00);
         OP_SKIP_ON_NULL_COPY_ACC: begin
            accD = memRd; // [RQ11]
            skipD = (memRd == 8'h00); // [RQ11]
         end
         OP_SKIP_ON_BIT_CLEAR: skipD = !memRd[ins.bitSel]; // [RQ9]
         OP_SKIP_ON_BIT_SET: skipD = memRd[ins.bitSel]; // [RQ9]
         OP_INCREMENT_SKIP_ON_NULL: begin
            memWe = 1'b1;
            memWd = incV; // [RQ10]
            skipD = (incV == 8'h00);
         end
         OP_DECREMENT_SKIP_ON_NULL: begin
            memWe = 1'b1;
            memWd = decV; // [RQ10]
            skipD = (decV == 8'h00);
         end
         OP_INCREMENT_SKIP_ON_NULL_TO_ACC: begin
            accD = incV; // [RQ10]
            skipD = (incV == 8'h00);
         end
         OP_DECREMENT_SKIP_ON_NULL_TO_ACC: begin
            accD = decV; // [RQ10]
            skipD = (decV == 8'h00);
         end
         OP_TABLE_FETCH_CURRENT_PAGE, OP_TABLE_FETCH_FINAL_PAGE: tabGo = 1'b1; // [RQ13]
         OP_WATCHDOG_CLEAR_OP: begin
            wdtD = 1'b1;
            flagD.watchdogExpiredFlag = 1'b0;
            flagD.sleepEnteredFlag = 1'b0;
         end
         // A lone pre-clear only arms; the partner must follow at once
         OP_WATCHDOG_PRECLEAR_ONE: begin
            wdtD = wdtArm_q[1]; // [RQ20]
            armD = wdtArm_q[1] ? 2'b00 : 2'b01;
            if (wdtArm_q[1]) begin
               flagD.watchdogExpiredFlag = 1'b0;
               flagD.sleepEnteredFlag = 1'b0;
            end
         end
         OP_WATCHDOG_PRECLEAR_TWO: begin
            wdtD = wdtArm_q[0]; // [RQ20]
            armD = wdtArm_q[0] ? 2'b00 : 2'b10;
            if (wdtArm_q[0]) begin
               flagD.watchdogExpiredFlag = 1'b0;
               flagD.sleepEnteredFlag = 1'b0;
            end
         end
         OP_HALT: begin
            haltGo = 1'b1; // [RQ14]
            wdtD = 1'b1;
            flagD.watchdogExpiredFlag = 1'b0; // [RQ14]
            flagD.sleepEnteredFlag = 1'b1; // [RQ14]
         end
         OP_NIBBLE_EXCHANGE: begin
            memWe = 1'b1;
            memWd = {memRd[3:0], memRd[7:4]}; // [RQ15]
         end
         OP_NIBBLE_EXCHANGE_TO_ACC: accD = {memRd[3:0], memRd[7:4]}; // [RQ15]
         OP_SUM_WITH_CY_TO_ACC, OP_SUM_TO_ACC: begin
            accD = sum9[7:0]; // [RQ16] [RQ18]
            flagD = addFl;
         end
         OP_SUM_WITH_CY_TO_MEMORY: begin
            memWe = 1'b1;
            memWd = sum9[7:0]; // [RQ17]
            flagD = addFl;
         end
         default: ;
      endcase
   end

   // Accumulator and flags; watchdog and sleep flags are not software writable
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         acc_q <= ACC_RST;
         flag_q <= STATUS_RST;
      end else if (exe) begin
         acc_q <= accD;
         flag_q <= flagD;
      end else if (swAcc) begin
         acc_q <= s_axi_wdata[7:0];
      end else if (swStat) begin
         flag_q <= {s_axi_wdata[7:6], flag_q.watchdogExpiredFlag, flag_q.sleepEnteredFlag, s_axi_wdata[3:0]};
      end
   end

   // Program counter and four-deep return stack; deeper nesting wraps silently
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pc_q <= PC_RST;
         sp_q <= '0;
      end else if (exe) begin
         pc_q <= pcD;
         if (pushEn) begin
            sp_q <= sp_q + 2'h1;
         end else if (popEn) begin
            sp_q <= sp_q - 2'h1;
         end
      end
   end

   // Return addresses hold data only, so they need no reset
   always_ff @(posedge clk_sys) begin
      if (exe && pushEn) begin
         stack_q[sp_q] <= pc_q + 10'h001;
      end
   end

   // Skip, watchdog pairing and its clear pulse
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         skipPending_q <= 1'b0;
         wdtArm_q <= 2'b00;
         wdtClear_q <= 1'b0;
      end else begin
         wdtClear_q <= exe && wdtD; // [RQ20]
         if (exe) begin
            skipPending_q <= skipD; // [RQ19]
            wdtArm_q <= armD;
         end
      end
   end

   // Power-down: instructions are dropped until software wakes the core
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sleep_q <= 1'b0;
      end else if (exe && haltGo) begin
         sleep_q <= 1'b1; // [RQ14]
      end else if (swState && s_axi_wdata[WAKE_BIT]) begin
         sleep_q <= 1'b0;
      end
   end

   // Table fetch takes one extra cycle for the registered ROM address
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= ST_READY;
         romAddr_q <= PC_RST;
         tabAddr_q <= '0;
         table_upper_byte_q <= '0;
      end else begin
         case (state_q)
            ST_READY: begin
               if (exe && tabGo) begin
                  romAddr_q <= {(opEff == OP_TABLE_FETCH_FINAL_PAGE) ? PAGE_LAST : pc_q[PC_W-1:DATA_W], acc_q};
                  tabAddr_q <= ins.memAddr;
                  state_q <= ST_TABLE;
               end
            end
            ST_TABLE: begin
               table_upper_byte_q <= romData[ROM_W-1:DATA_W]; // [RQ13]
               state_q <= ST_READY;
            end
            default: state_q <= ST_READY;
         endcase
      end
   end

   // Software memory pointer
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mptr_q <= '0;
      end else if (swMptr) begin
         mptr_q <= s_axi_wdata[MADDR_W-1:0];
      end
   end

   // Data memory; the three writers never coincide
   always_ff @(posedge clk_sys) begin
      if (state_q == ST_TABLE) begin
         mem_q[tabAddr_q] <= romData[DATA_W-1:0]; // [RQ13]
      end else if (exe && memWe) begin
         mem_q[ins.memAddr] <= memWd;
      end else if (swMdata) begin
         mem_q[mptr_q] <= s_axi_wdata[DATA_W-1:0];
      end
   end

   // Write response; unmapped words answer with a slave error
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bValid_q <= 1'b0;
         bResp_q <= RESP_OKAY;
      end else if (wrGo) begin
         bValid_q <= 1'b1;
         bResp_q <= isMapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bValid_q <= 1'b0;
      end
   end

   // Read channel: one read at a time, data registered
   assign arGo = s_axi_arvalid && !rValid_q;
   assign s_axi_arready = arGo;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rValid_q <= 1'b0;
         rResp_q <= RESP_OKAY;
         rData_q <= 32'h0000_0000;
      end else if (arGo) begin
         rValid_q <= 1'b1;
         rResp_q <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (wordAddr(s_axi_araddr))
            REG_ACC: rData_q <= {24'h00_0000, acc_q};
            REG_STATUS: rData_q <= {24'h00_0000, flag_q};
            REG_TABLE_UPPER_BYTE: rData_q <= {26'h000_0000, table_upper_byte_q};
            REG_PC: rData_q <= {22'h00_0000, pc_q};
            REG_STATE: rData_q <= {27'h000_0000, wdtArm_q, state_q == ST_TABLE, skipPending_q, sleep_q};
            REG_MPTR: rData_q <= {25'h000_0000, mptr_q};
            REG_MDATA: rData_q <= {24'h00_0000, mem_q[mptr_q]};
            default: rData_q <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         rValid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rresp = rResp_q;
   assign s_axi_rdata = rData_q;
   assign romAddr = romAddr_q;
   assign sleepMode = sleep_q;
   assign wdtClear = wdtClear_q;

   // Checks on the executed results
   property p_rotKeep;
      exe && (opEff inside {OP_ROTATE_RIGHT_TO_ACC, OP_ROTATE_LEFT_IN_PLACE}) |=> flag_q == $past(flag_q);
   endproperty
   a_rotKeep: assert property (p_rotKeep) else $error("Plain rotate changed a flag"); // [RQ1]

   property p_rotCy;
      exe && opEff == OP_ROTATE_RIGHT_VIA_CY_TO_ACC |=>
         acc_q == {$past(flag_q.cy), $past(memRd[7:1])} && flag_q.cy == $past(memRd[0]);
   endproperty
   a_rotCy: assert property (p_rotCy) else $error("Rotate through carry wrong"); // [RQ2]

   property p_load;
      exe && opEff == OP_TRANSFER_MEM_TO_ACC |=> acc_q == $past(memRd) && flag_q == $past(flag_q);
   endproperty
   a_load: assert property (p_load) else $error("Memory load to acc wrong or touched flags"); // [RQ3] [RQ4]

   property p_bitSet;
      exe && opEff == OP_BIT_SET |=> mem_q[$past(ins.memAddr)] == ($past(memRd) | $past(bitMask));
   endproperty
   a_bitSet: assert property (p_bitSet) else $error("Bit set wrong"); // [RQ5]

   property p_branch;
      exe && opEff == OP_UNCONDITIONAL_BRANCH |=> pc_q == $past(ins.operand);
   endproperty
   a_branch: assert property (p_branch) else $error("Branch target not taken"); // [RQ6]

   property p_bitSkip;
      exe && opEff == OP_SKIP_ON_BIT_CLEAR |=> skipPending_q == !$past(memRd[ins.bitSel]);
   endproperty
   a_bitSkip: assert property (p_bitSkip) else $error("Bit-test skip decision wrong"); // [RQ9]

   property p_skipNop;
      skipPending_q && exe |=> !skipPending_q && acc_q == $past(acc_q) && pc_q == $past(pc_q) + 10'h001;
   endproperty
   a_skipNop: assert property (p_skipNop) else $error("Skipped instruction had an effect"); // [RQ19]

   property p_exitImm;
      exe && opEff == OP_SUBROUTINE_EXIT_IMM |=> acc_q == $past(ins.operand[7:0]) && sp_q == $past(sp_q) - 2'h1;
   endproperty
   a_exitImm: assert property (p_exitImm) else $error("Exit with immediate wrong"); // [RQ12]

   property p_table;
      exe && tabGo |=> state_q == ST_TABLE ##1 table_upper_byte_q == $past(romData[ROM_W-1:DATA_W]) && state_q == ST_READY;
   endproperty
   a_table: assert property (p_table) else $error("Table fetch sequence wrong"); // [RQ13]

   property p_halt;
      exe && opEff == OP_HALT |=> sleep_q && flag_q.sleepEnteredFlag && !flag_q.watchdogExpiredFlag && wdtClear_q;
   endproperty
   a_halt: assert property (p_halt) else $error("Halt did not enter power-down"); // [RQ14]

   property p_sum;
      exe && opEff == OP_SUM_TO_ACC |=> acc_q == 8'($past(acc_q) + $past(memRd)) &&
         flag_q[7:4] == $past(flag_q[7:4]);
   endproperty
   a_sum: assert property (p_sum) else $error("Plain sum wrong"); // [RQ18]

   property p_preOne;
      exe && opEff == OP_WATCHDOG_PRECLEAR_ONE && !wdtArm_q[1] |=> !wdtClear_q && flag_q == $past(flag_q);
   endproperty
   a_preOne: assert property (p_preOne) else $error("Lone pre-clear acted"); // [RQ20]

   c_skip: cover property (exe && skipD ##1 exe);
   c_table: cover property (exe && tabGo ##1 s_axi_bvalid);
   c_pair: cover property (exe && opEff == OP_WATCHDOG_PRECLEAR_ONE ##[1:8] wdtClear_q);
endmodule

// *** shared/mie_pkg.sv ***
// Shared constants, opcodes and carrier types of the instruction execution core
package mie_pkg;
   // Datapath widths and depths
   localparam int DATA_W = 8;
   localparam int MADDR_W = 7;
   localparam int PC_W = 10;
   localparam int ROM_W = 14;
   localparam int TABLE_UPPER_BYTE_W = ROM_W - DATA_W;
   localparam int MEM_DEPTH = 128;
   localparam int STACK_DEPTH = 4;
   localparam int SP_W = 2;
   localparam logic [1:0] PAGE_LAST = 2'h3;
   // Register byte offsets on the AXI4-Lite port
   localparam logic [7:0] REG_INSTR = 8'h00;
   localparam logic [7:0] REG_ACC = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_TABLE_UPPER_BYTE = 8'h0C;
   localparam logic [7:0] REG_PC = 8'h10;
   localparam logic [7:0] REG_STATE = 8'h14;
   localparam logic [7:0] REG_MPTR = 8'h18;
   localparam logic [7:0] REG_MDATA = 8'h1C;
   // Reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [9:0] PC_RST = 10'h000;
   // Field positions of the state register
   localparam int WAKE_BIT = 0;
   localparam int SLEEP_BIT = 0;
   localparam int SKIP_BIT = 1;
   localparam int BUSY_BIT = 2;
   localparam int ARM_LSB = 3;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Operations, numbered in declaration order from zero
   typedef enum logic [5:0] {
      OP_NOP,
      OP_ROTATE_RIGHT_TO_ACC,
      OP_ROTATE_RIGHT_IN_PLACE,
      OP_ROTATE_RIGHT_VIA_CY_TO_ACC,
      OP_ROTATE_RIGHT_VIA_CY,
      OP_ROTATE_LEFT_TO_ACC,
      OP_ROTATE_LEFT_IN_PLACE,
      OP_ROTATE_LEFT_VIA_CY_TO_ACC,
      OP_ROTATE_LEFT_VIA_CY,
      OP_TRANSFER_MEM_TO_ACC,
      OP_TRANSFER_ACC_TO_MEM,
      OP_TRANSFER_IMM_TO_ACC,
      OP_BIT_CLEAR,
      OP_BIT_SET,
      OP_UNCONDITIONAL_BRANCH,
      OP_SUBROUTINE_ENTRY,
      OP_SUBROUTINE_EXIT,
      OP_SUBROUTINE_EXIT_IMM,
      OP_SKIP_ON_NULL,
      OP_SKIP_ON_NULL_COPY_ACC,
      OP_SKIP_ON_BIT_CLEAR,
      OP_SKIP_ON_BIT_SET,
      OP_INCREMENT_SKIP_ON_NULL,
      OP_DECREMENT_SKIP_ON_NULL,
      OP_INCREMENT_SKIP_ON_NULL_TO_ACC,
      OP_DECREMENT_SKIP_ON_NULL_TO_ACC,
      OP_TABLE_FETCH_CURRENT_PAGE,
      OP_TABLE_FETCH_FINAL_PAGE,
      OP_WATCHDOG_CLEAR_OP,
      OP_WATCHDOG_PRECLEAR_ONE,
      OP_WATCHDOG_PRECLEAR_TWO,
      OP_HALT,
      OP_NIBBLE_EXCHANGE,
      OP_NIBBLE_EXCHANGE_TO_ACC,
      OP_SUM_WITH_CY_TO_ACC,
      OP_SUM_WITH_CY_TO_MEMORY,
      OP_SUM_TO_ACC
   } mie_op_t;

   // Instruction word as written to the instruction register
   typedef struct packed {
      logic [1:0] rsvTop;
      mie_op_t op;
      logic rsvA;
      logic [2:0] bitSel;
      logic rsvB;
      logic [6:0] memAddr;
      logic [1:0] rsvC;
      logic [9:0] operand;
   } mie_instr_t;

   // Status flags, most significant first
   typedef struct packed {
      logic generalFlagTwo;
      logic generalFlagOne;
      logic watchdogExpiredFlag;
      logic sleepEnteredFlag;
      logic ov;
      logic z;
      logic ac;
      logic cy;
   } mie_status_t;

   typedef enum logic {ST_READY, ST_TABLE} mie_state_t;
endpackage

// *** tb/mie_rom_model.sv ***
// Zero-latency program ROM model for table fetches
`timescale 1ns/10ps
module mie_rom_model
   import mie_pkg::*;
(
   input wire logic [PC_W-1:0] romAddr,
   output logic [ROM_W-1:0] romData
);
   // Pattern tied to the low address byte, so a wrong offset shows; the page bits are not used
   assign romData = {romAddr[5:0], ~romAddr[7:0]};
endmodule

// *** tb/mie_exec_core_test.sv ***
// Directed register-level test of the execution core
`timescale 1ns/10ps
module mie_exec_core_test
   import mie_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
   logic [31:0] wData = 32'h0000_0000;
   logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
   logic awReady, wReady, bValid, arReady, rValid, sleepMode, wdtClear;
   logic [1:0] bResp, rResp, r;
   logic [31:0] rData, v;
   logic [PC_W-1:0] romAddr;
   logic [ROM_W-1:0] romData;
   int n_fail = 0;
   int samples_checked = 0;
   int nClr = 0;
   always #2 clk_sys = ~clk_sys;
   // Count watchdog clear pulses, each stands for one cycle only
   always @(posedge clk_sys) begin
      if (wdtClear === 1'b1) begin
         nClr <= nClr + 1;
      end
   end
   // Full-word strobes only; narrow writes are outside this test
   mie_exec_core dut (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
      .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
      .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .romAddr(romAddr),
      .romData(romData), .sleepMode(sleepMode), .wdtClear(wdtClear));
   mie_rom_model rom (.romAddr(romAddr), .romData(romData));
   // Each handshake ends at the rising edge where ready or valid is seen high; one idle edge follows
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awAddr <= a;
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      do @(posedge clk_sys); while (awReady !== 1'b1);
      awValid <= 1'b0;
      wValid <= 1'b0;
      do @(posedge clk_sys); while (bValid !== 1'b1);
      bReady <= 1'b0;
      samples_checked++;
      if (bResp !== RESP_OKAY) begin
         n_fail++;
         $display("ERROR %0t write %h refused", $time, a);
      end
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      do @(posedge clk_sys); while (arReady !== 1'b1);
      arValid <= 1'b0;
      do @(posedge clk_sys); while (rValid !== 1'b1);
      v = rData;
      r = rResp;
      rReady <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      samples_checked++;
      if (v !== e || r !== RESP_OKAY) begin
         n_fail++;
         $display("ERROR %0t read %h got %h exp %h", $time, a, v, e);
      end
   endtask
   task automatic ex(input mie_op_t o, input logic [2:0] b, input logic [6:0] m, input logic [9:0] x);
      mie_instr_t i;
      i = '0;
      i.op = o;
      i.bitSel = b;
      i.memAddr = m;
      i.operand = x;
      wr(REG_INSTR, 32'(i));
   endtask
   task automatic setm(input logic [6:0] m, input logic [7:0] d);
      wr(REG_MPTR, {25'h0, m});
      wr(REG_MDATA, {24'h0, d});
   endtask
   task automatic mchk(input logic [6:0] m, input logic [7:0] e);
      wr(REG_MPTR, {25'h0, m});
      chk(REG_MDATA, {24'h0, e});
   endtask
   task automatic print_verdict;
      if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Whole sequence needs a couple of hundred cycles; this limit of 50000 cycles is far beyond it
   initial begin
      #200000;
      n_fail++;
      print_verdict();
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      // Carry enters bit 7 and bit 0 leaves into carry
      wr(REG_ACC, 32'h0000_0081);
      wr(REG_STATUS, 32'h0000_0001);
      setm(7'h05, 8'h96);
      ex(OP_ROTATE_RIGHT_VIA_CY_TO_ACC, 3'h0, 7'h05, 10'h000);
      chk(REG_ACC, 32'h0000_00CB);
      chk(REG_STATUS, 32'h0000_0000);
      wr(REG_STATUS, 32'h0000_00C5);
      ex(OP_ROTATE_LEFT_IN_PLACE, 3'h0, 7'h05, 10'h000);
      mchk(7'h05, 8'h2D);
      // Zero flag set while loading a non-zero byte must stay set
      ex(OP_TRANSFER_MEM_TO_ACC, 3'h0, 7'h05, 10'h000);
      chk(REG_ACC, 32'h0000_002D);
      chk(REG_STATUS, 32'h0000_00C5);
      setm(7'h06, 8'h00);
      ex(OP_BIT_SET, 3'h7, 7'h06, 10'h000);
      mchk(7'h06, 8'h80);
      // Bit 0 is clear, so the immediate load behind it is dropped
      ex(OP_SKIP_ON_BIT_CLEAR, 3'h0, 7'h06, 10'h000);
      ex(OP_TRANSFER_IMM_TO_ACC, 3'h0, 7'h00, 10'h355);
      chk(REG_ACC, 32'h0000_002D);
      ex(OP_TRANSFER_IMM_TO_ACC, 3'h0, 7'h00, 10'h355);
      chk(REG_ACC, 32'h0000_0055);
      setm(7'h07, 8'hFF);
      ex(OP_INCREMENT_SKIP_ON_NULL, 3'h0, 7'h07, 10'h000);
      ex(OP_TRANSFER_IMM_TO_ACC, 3'h0, 7'h00, 10'h011);
      chk(REG_ACC, 32'h0000_0055);
      mchk(7'h07, 8'h00);
      // Signed overflow and half carry, general flags kept
      wr(REG_STATUS, 32'h0000_00C0);
      wr(REG_ACC, 32'h0000_007F);
      setm(7'h08, 8'h01);
      ex(OP_SUM_WITH_CY_TO_ACC, 3'h0, 7'h08, 10'h000);
      chk(REG_ACC, 32'h0000_0080);
      chk(REG_STATUS, 32'h0000_00CA);
      wr(REG_ACC, 32'h0000_0012);
      ex(OP_TABLE_FETCH_FINAL_PAGE, 3'h0, 7'h09, 10'h000);
      chk(REG_TABLE_UPPER_BYTE, 32'h0000_0012);
      mchk(7'h09, 8'hED);
      ex(OP_HALT, 3'h0, 7'h00, 10'h000);
      chk(REG_STATUS, 32'h0000_00DA);
      chk(REG_STATE, 32'h0000_0001);
      samples_checked++;
      if (sleepMode !== 1'b1 || nClr != 1) begin
         n_fail++;
         $display("ERROR %0t sleep output or clear pulse wrong", $time);
      end
      // Wake, then a pre-clear pair in reverse order completes the clear
      wr(REG_STATE, 32'h0000_0001);
      ex(OP_WATCHDOG_PRECLEAR_TWO, 3'h0, 7'h00, 10'h000);
      chk(REG_STATE, 32'h0000_0010);
      chk(REG_STATUS, 32'h0000_00DA);
      ex(OP_WATCHDOG_PRECLEAR_ONE, 3'h0, 7'h00, 10'h000);
      chk(REG_STATUS, 32'h0000_00CA);
      ex(OP_UNCONDITIONAL_BRANCH, 3'h0, 7'h00, 10'h2A5);
      chk(REG_PC, 32'h0000_02A5);
      ex(OP_SUM_TO_ACC, 3'h0, 7'h09, 10'h000);
      chk(REG_ACC, 32'h0000_00FF);
      chk(REG_STATUS, 32'h0000_00C0);
      samples_checked++;
      if (sleepMode !== 1'b0 || nClr != 2) begin
         n_fail++;
         $display("ERROR %0t wake or pair clear pulse wrong", $time);
      end
      // Unmapped offset answers with an error and zero data
      rd(8'h20);
      samples_checked++;
      if (r !== RESP_SLVERR || v !== 32'h0000_0000) begin
         n_fail++;
         $display("ERROR %0t unmapped read not refused", $time);
      end
      print_verdict();
   end
endmodule
